// >>> hdl/bbl_params.svh
// Register map, field positions, reset values and response codes for the raster logic and line FIFO block
// Contract
// - Each result bit is function-select bit indexed by source and destination bits.
// - Line-mode select high gives line drawing; FIFO moves no data then.
// - Line drawing mode disregards the shift count; no barrel alignment reaches result.
// - Line mode ignores programmed masks; pair of masks comes from pixel address.
// - Destination bits with mask zero stay unchanged; line mode touches one bit.
// - Pixel address maps to data bit equal to its ones-complement; pixel 0 is bit 15.
// - Line mode copies the pixel input latch bit onto all sixteen source bits.
// - Line mode drives pixel output with selected result bit; block mode floats it.
// - FIFO is sixteen 16-bit entries, separate ports, each with one-hot ring counter.
// - Write strobe advances write ring, read strobe read ring; reset selects entry 0.
// - Rings step 0 to 15 ascending, then wrap to 0 silently.
// - FIFO write stores shifter or logic output per source select, then advances.
// - Selected entry loads master every cycle; read strobe moves it to output.
// - Same entry read and written in one cycle returns the old contents.
// - FIFO reads, writes or both run on consecutive cycles without stalling.
// - With no wait states a new operand is accepted every clock.
// - Data latched while source select is high goes to the source input latch.
`ifndef BBL_PARAMS_SVH
`define BBL_PARAMS_SVH

`define BBL_ADDR_W 8
`define BBL_CTRL_OFF 8'h00
`define BBL_LMASK_OFF 8'h04
`define BBL_RMASK_OFF 8'h08
`define BBL_STATUS_OFF 8'h0C
`define BBL_RESULT_OFF 8'h10
`define BBL_FIFO_OUT_OFF 8'h14

`define BBL_FS_LSB 0
`define BBL_STAT_WR_LSB 0
`define BBL_STAT_RD_LSB 4
`define BBL_STAT_LINE_BIT 8
`define BBL_STAT_PIL_BIT 9

`define BBL_FS_RST 4'hC
`define BBL_MASK_RST 16'hFFFF
`define BBL_RING_RST 16'h0001

`define BBL_RESP_OKAY 2'h0
`define BBL_RESP_SLVERR 2'h2

`endif

// >>> hdl/bbl_pkg.sv
// Types shared by the raster logic and line FIFO block
package bbl_pkg;

    typedef logic [15:0] bbl_word_type;

    // Register state of the block apart from the FIFO entries
    typedef struct packed {
        bbl_word_type wr_ring;
        bbl_word_type rd_ring;
        bbl_word_type master;
        bbl_word_type fifo_out;
        bbl_word_type src_latch;
        bbl_word_type dst_latch;
        bbl_word_type result;
        logic pixel_input_latch;
        logic pix_out;
        logic pix_oe;
        logic [3:0] fs;
        bbl_word_type lmask;
        bbl_word_type rmask;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bbl_state_type;

endpackage

// >>> hdl/bbl_top.sv
// Raster logic unit, line drawing datapath and line FIFO with an AXI4-Lite register slave
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`include "bbl_params.svh"

module bbl_top import bbl_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Controller strobes and mode
    input wire logic line_mode_sel,
    input wire logic source_enable_select,
    input wire logic data_latch_strobe,
    input wire logic fifo_write_strobe,
    input wire logic fifo_read_strobe,
    // Pixel port
    input wire logic [3:0] pixel_address,
    input wire logic pixel_data_in,
    input wire logic pixel_latch_strobe,
    output logic pixel_data_out,
    output logic pixel_data_oe,
    // Memory data and shifter path
    input wire logic [15:0] data_in,
    input wire logic [15:0] shifter_word,
    output logic [15:0] source_latch_word,
    output logic [15:0] result_word
);

    bbl_state_type s_r;
    bbl_state_type s_nxt;
    bbl_word_type fifo_mem [16];
    bbl_word_type src_op;
    bbl_word_type eff_mask;
    bbl_word_type lu_res;
    bbl_word_type fifo_wdata;
    bbl_word_type rd_ring_nxt;
    logic fifo_we;
    logic fifo_re;
    logic wr_fire;
    logic wr_hit;

    // One-hot ring selection to entry number
    function automatic logic [3:0] ring_idx(input bbl_word_type ring);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (ring[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // Left and right masks of line mode; their AND is the single target bit
    function automatic bbl_word_type line_mask(input logic [3:0] pa, input logic left);
        bbl_word_type m;
        logic [3:0] bitpos;
        m = 16'h0000;
        bitpos = ~pa;
        for (int i = 0; i < 16; i++) begin
            m[i] = left ? (4'(i) <= bitpos) : (4'(i) >= bitpos);
        end
        return m;
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic bbl_word_type merge16(input bbl_word_type old, input logic [31:0] d,
                                             input logic [3:0] st);
        return {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
    endfunction

    // Line mode bypasses the FIFO and any alignment: source is the pixel latch
    assign src_op = line_mode_sel ? {16{s_r.pixel_input_latch}} : s_r.fifo_out;

    // Programmed masks give way to the generated pair in line mode
    assign eff_mask = line_mode_sel
        ? (line_mask(pixel_address, 1'b1) & line_mask(pixel_address, 1'b0))
        : (s_r.lmask & s_r.rmask);

    // Per-bit function lookup, masked bits keep the destination
    for (genvar g = 0; g < 16; g++) begin : g_lu
        assign lu_res[g] = eff_mask[g] ? s_r.fs[{src_op[g], s_r.dst_latch[g]}]
                                       : s_r.dst_latch[g];
    end

    // FIFO strobes are dead in line mode so no data moves through it
    assign fifo_we = fifo_write_strobe && !line_mode_sel;
    assign fifo_re = fifo_read_strobe && !line_mode_sel;
    assign fifo_wdata = source_enable_select ? shifter_word : lu_res;
    assign rd_ring_nxt = fifo_re ? {s_r.rd_ring[14:0], s_r.rd_ring[15]} : s_r.rd_ring;
    // Write into the entry the master will fetch next; lets a read follow a write by one cycle
    assign wr_hit = fifo_we && (s_r.wr_ring == rd_ring_nxt);

    // Entry array; contents are never cleared
    always_ff @(posedge aclk) begin
        if (fifo_we) begin
            fifo_mem[ring_idx(s_r.wr_ring)] <= fifo_wdata;
        end
    end

    // AXI handshakes: one write and one read outstanding
    assign awready = !s_r.aw_got && !s_r.bvalid;
    assign wready = !s_r.w_got && !s_r.bvalid;
    assign arready = !s_r.rvalid;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;
    // Both halves held or arriving now; built from inputs and s_r so it cannot loop through s_nxt
    assign wr_fire = (s_r.aw_got || (awvalid && awready)) && (s_r.w_got || (wvalid && wready)) && !s_r.bvalid;

    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        // Latches and ring counters, all single-cycle so strobes may come every clock
        if (data_latch_strobe) begin
            if (source_enable_select) begin
                s_nxt.src_latch = data_in;
            end else begin
                s_nxt.dst_latch = data_in;
            end
        end
        if (pixel_latch_strobe) begin
            s_nxt.pixel_input_latch = pixel_data_in;
        end
        if (fifo_we) begin
            s_nxt.wr_ring = {s_r.wr_ring[14:0], s_r.wr_ring[15]};
        end
        if (fifo_re) begin
            s_nxt.fifo_out = s_r.master;
        end
        s_nxt.rd_ring = rd_ring_nxt;
        // Read-ahead of the entry the read ring will point at
        s_nxt.master = wr_hit ? fifo_wdata : fifo_mem[ring_idx(rd_ring_nxt)];
        s_nxt.result = lu_res;
        s_nxt.pix_out = lu_res[~pixel_address];
        s_nxt.pix_oe = line_mode_sel;
        // Write channel capture in either order
        if (awvalid && awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.w_data = wdata;
            s_nxt.w_strb = wstrb;
        end
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_fire) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `BBL_RESP_OKAY;
            unique case ({s_nxt.aw_addr[7:2], 2'b00})
                `BBL_CTRL_OFF: begin
                    if (s_nxt.w_strb[0]) begin
                        s_nxt.fs = s_nxt.w_data[`BBL_FS_LSB +: 4];
                    end
                end
                `BBL_LMASK_OFF: s_nxt.lmask = merge16(s_r.lmask, s_nxt.w_data, s_nxt.w_strb);
                `BBL_RMASK_OFF: s_nxt.rmask = merge16(s_r.rmask, s_nxt.w_data, s_nxt.w_strb);
                `BBL_STATUS_OFF, `BBL_RESULT_OFF, `BBL_FIFO_OUT_OFF: begin
                end
                default: s_nxt.bresp = `BBL_RESP_SLVERR;
            endcase
        end
        // Read channel
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = `BBL_RESP_OKAY;
            s_nxt.rdata = 32'h0000_0000;
            unique case ({araddr[7:2], 2'b00})
                `BBL_CTRL_OFF: s_nxt.rdata[`BBL_FS_LSB +: 4] = s_r.fs;
                `BBL_LMASK_OFF: s_nxt.rdata[15:0] = s_r.lmask;
                `BBL_RMASK_OFF: s_nxt.rdata[15:0] = s_r.rmask;
                `BBL_STATUS_OFF: begin
                    s_nxt.rdata[`BBL_STAT_WR_LSB +: 4] = ring_idx(s_r.wr_ring);
                    s_nxt.rdata[`BBL_STAT_RD_LSB +: 4] = ring_idx(s_r.rd_ring);
                    s_nxt.rdata[`BBL_STAT_LINE_BIT] = line_mode_sel;
                    s_nxt.rdata[`BBL_STAT_PIL_BIT] = s_r.pixel_input_latch;
                end
                `BBL_RESULT_OFF: s_nxt.rdata[15:0] = s_r.result;
                `BBL_FIFO_OUT_OFF: s_nxt.rdata[15:0] = s_r.fifo_out;
                default: s_nxt.rresp = `BBL_RESP_SLVERR;
            endcase
        end
    end

    // State register; FIFO entries are left alone by reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= s_nxt;
            s_r.wr_ring <= `BBL_RING_RST;
            s_r.rd_ring <= `BBL_RING_RST;
            s_r.master <= fifo_mem[0]; // Read-ahead of entry 0 so a read right after reset is good
            s_r.fifo_out <= 16'h0000;
            s_r.src_latch <= 16'h0000;
            s_r.dst_latch <= 16'h0000;
            s_r.result <= 16'h0000;
            s_r.pixel_input_latch <= 1'b0;
            s_r.pix_out <= 1'b0;
            s_r.pix_oe <= 1'b0;
            s_r.fs <= `BBL_FS_RST;
            s_r.lmask <= `BBL_MASK_RST;
            s_r.rmask <= `BBL_MASK_RST;
            s_r.aw_got <= 1'b0;
            s_r.aw_addr <= 8'h00;
            s_r.w_got <= 1'b0;
            s_r.w_data <= 32'h0000_0000;
            s_r.w_strb <= 4'h0;
            s_r.bvalid <= 1'b0;
            s_r.bresp <= `BBL_RESP_OKAY;
            s_r.rvalid <= 1'b0;
            s_r.rdata <= 32'h0000_0000;
            s_r.rresp <= `BBL_RESP_OKAY;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Data outputs straight from flops
    assign source_latch_word = s_r.src_latch;
    assign result_word = s_r.result;
    assign pixel_data_out = s_r.pix_out;
    assign pixel_data_oe = s_r.pix_oe;

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_ready_s;
        wr_fire;
    endsequence

    sequence resp_held_s;
        bvalid && !bready;
    endsequence

    // Write into the entry the read ring selects, then read it on the next clock
    sequence wr_then_rd_s;
        (fifo_we && !fifo_re && s_r.wr_ring == s_r.rd_ring) ##1 fifo_re;
    endsequence

    a_fn_truth: assert property ((eff_mask[0] && src_op[0] && !s_r.dst_latch[0])
                                 |-> lu_res[0] == s_r.fs[2])
        else $error("logic unit bit 0 does not follow function bit 2");
    a_line_no_fifo: assert property (line_mode_sel |=> $stable(s_r.wr_ring) && $stable(s_r.rd_ring))
        else $error("FIFO ring moved in line mode");
    a_line_one_bit: assert property (line_mode_sel |-> eff_mask == (16'h8000 >> pixel_address))
        else $error("line mode mask is not the single pixel bit");
    a_mask_keep: assert property ((lu_res & ~eff_mask) == (s_r.dst_latch & ~eff_mask))
        else $error("unmasked destination bit changed");
    a_pix_select: assert property (line_mode_sel
                                   |=> pixel_data_oe && pixel_data_out == $past(lu_res[~pixel_address]))
        else $error("pixel output wrong in line mode");
    a_pix_float: assert property (!line_mode_sel |=> !pixel_data_oe)
        else $error("pixel output driven in block mode");
    a_line_src: assert property (line_mode_sel |-> src_op == {16{s_r.pixel_input_latch}})
        else $error("line mode source not replicated pixel bit");
    a_ring_onehot: assert property ($onehot(s_r.wr_ring) && $onehot(s_r.rd_ring))
        else $error("ring counter not one-hot");
    a_ring_wrap: assert property ((fifo_we && s_r.wr_ring == 16'h8000) |=> s_r.wr_ring == 16'h0001)
        else $error("write ring did not wrap to entry 0");
    a_read_master: assert property (fifo_re
                                    |=> s_r.fifo_out == $past(s_r.master) && !$stable(s_r.rd_ring))
        else $error("read strobe did not pass master to output");
    a_wr_to_rd: assert property (wr_then_rd_s |=> s_r.fifo_out == $past(fifo_wdata, 2))
        else $error("read after write returned stale word");
    a_axi_wresp: assert property (wr_ready_s |=> bvalid)
        else $error("write response not raised after both channels");
    a_resp_hold: assert property (resp_held_s |=> bvalid && $stable(bresp))
        else $error("write response dropped before it was taken");
    a_src_latch: assert property ((data_latch_strobe && source_enable_select)
                                  |=> source_latch_word == $past(data_in))
        else $error("source latch did not take the fetched word");

endmodule // bbl_top

// >>> testbench/bbl_mem_model.sv
// Zero-wait memory model that feeds operand words to the block
module bbl_mem_model (
    // Clock
    input wire logic clk,
    // Bench side
    input wire logic we,
    input wire logic en,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    // Block side
    output logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [16];
    logic [15:0] last_r = 16'h0000;
    // Storage, and the last word put on the bus
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        if (en) begin
            last_r <= mem[addr];
        end
    end
    // New word every clock; released bus shows the inverse so stale data never matches
    assign rdata = en ? mem[addr] : ~last_r;
endmodule // bbl_mem_model

// >>> testbench/tb_top.sv
// Self-checking bench for the raster logic and line FIFO block
`include "bbl_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, pixel_address, mem_addr, fs;
    logic [1:0] bresp, rresp, r;
    logic line_mode_sel, source_enable_select, data_latch_strobe, fifo_write_strobe, fifo_read_strobe;
    logic pixel_data_in, pixel_latch_strobe, pixel_data_out, pixel_data_oe, mem_we, mem_en, pixel_input_latch, b;
    logic [15:0] data_in, shifter_word, source_latch_word, result_word, mem_wdata, fo, dst, lm, rm, e;
    logic [15:0] fm [16];
    logic [15:0] memv [16];
    int wp = 0;
    int rp = 0;
    int i, cyc = 0;
    int miscompares = 0;
    int total_checks = 0;

    bbl_top bbl_top_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .line_mode_sel(line_mode_sel),
        .source_enable_select(source_enable_select), .data_latch_strobe(data_latch_strobe),
        .fifo_write_strobe(fifo_write_strobe), .fifo_read_strobe(fifo_read_strobe),
        .pixel_address(pixel_address), .pixel_data_in(pixel_data_in), .pixel_latch_strobe(pixel_latch_strobe),
        .pixel_data_out(pixel_data_out), .pixel_data_oe(pixel_data_oe), .data_in(data_in),
        .shifter_word(shifter_word), .source_latch_word(source_latch_word), .result_word(result_word));
    bbl_mem_model bbl_mem_model_i (.clk(aclk), .we(mem_we), .en(mem_en), .addr(mem_addr), .wdata(mem_wdata),
        .rdata(data_in));

    // Clock, 100 ns period
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            final_report;
        end
    end

    task final_report;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Write one register; extra edge at the end keeps drivers from reassigning in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
        logic done;
        done = 1'b0;
        awaddr <= a;
        wdata <= dv;
        {awvalid, wvalid, bready} <= 3'b111;
        while (!done) begin
            @(posedge aclk);
            if (bvalid === 1'b1) begin
                chk(32'(bresp), 32'(er));
                bready <= 1'b0;
                done = 1'b1;
            end
            if (awvalid && awready === 1'b1) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                wvalid <= 1'b0;
            end
        end
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
        logic done;
        done = 1'b0;
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        while (!done) begin
            @(posedge aclk);
            if (rvalid === 1'b1) begin
                dv = rdata;
                rv = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
            if (arvalid && arready === 1'b1) begin
                arvalid <= 1'b0;
            end
        end
        tick(1);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] ev);
        logic [31:0] dv;
        logic [1:0] rv;
        rd(a, dv, rv);
        chk(dv, ev);
    endtask
    // Reference logic unit: selected function where the mask is set, else destination kept
    function automatic logic [15:0] lu(input logic line, input logic [3:0] pa);
        logic [15:0] s, m, q;
        s = line ? {16{pixel_input_latch}} : fo;
        m = line ? 16'h0001 << (4'hF - pa) : lm & rm;
        for (int k = 0; k < 16; k++) begin
            q[k] = m[k] ? fs[{s[k], dst[k]}] : dst[k];
        end
        return q;
    endfunction
    function automatic logic [31:0] st(input logic line);
        return {22'h0, pixel_input_latch, line, 4'(rp), 4'(wp)};
    endfunction

    // Main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, line_mode_sel, source_enable_select, aresetn} = '0;
        {data_latch_strobe, fifo_write_strobe, fifo_read_strobe, pixel_latch_strobe, pixel_data_in} = '0;
        {awaddr, araddr, wdata, pixel_address, mem_addr, shifter_word, mem_wdata, mem_we, mem_en, pixel_input_latch} = '0;
        wstrb = 4'hF;
        d = $urandom(32'h275D);
        tick(16);
        aresetn <= 1'b1;
        // Preload memory with random words
        mem_we <= 1'b1;
        for (i = 0; i < 16; i++) begin
            memv[i] = 16'($urandom);
            mem_addr <= 4'(i);
            mem_wdata <= memv[i];
            tick(1);
        end
        mem_we <= 1'b0;
        // Reset values, read-only and unmapped places
        rdc(`BBL_CTRL_OFF, 32'h0000000C);
        rdc(`BBL_LMASK_OFF, 32'h0000FFFF);
        rdc(`BBL_STATUS_OFF, st(1'b0));
        rd(8'h18, d, r);
        chk(32'(r), 32'(`BBL_RESP_SLVERR));
        chk(d, 32'h0);
        wr(8'h1C, 32'h0, `BBL_RESP_SLVERR);
        wr(`BBL_STATUS_OFF, 32'hFFFF, `BBL_RESP_OKAY);
        rdc(`BBL_STATUS_OFF, st(1'b0));
        lm = 16'($urandom);
        rm = 16'($urandom);
        wr(`BBL_LMASK_OFF, 32'(lm), `BBL_RESP_OKAY);
        wr(`BBL_RMASK_OFF, 32'(rm), `BBL_RESP_OKAY);
        rdc(`BBL_RMASK_OFF, 32'(rm));
        // Sixteen back-to-back shifter words wrap the write ring
        {source_enable_select, fifo_write_strobe} <= 2'b11;
        for (i = 0; i < 16; i++) begin
            fm[i] = 16'($urandom);
            shifter_word <= fm[i];
            tick(1);
        end
        fifo_write_strobe <= 1'b0;
        rdc(`BBL_STATUS_OFF, st(1'b0));
        // Drain one entry at a time
        for (i = 0; i < 16; i++) begin
            fifo_read_strobe <= 1'b1;
            tick(1);
            fifo_read_strobe <= 1'b0;
            fo = fm[i];
            rp = (i + 1) % 16;
            rdc(`BBL_FIFO_OUT_OFF, 32'(fo));
            rdc(`BBL_STATUS_OFF, st(1'b0));
        end
        // Same entry read and written together gives the old word
        {fifo_write_strobe, fifo_read_strobe} <= 2'b11;
        shifter_word <= ~fm[0];
        tick(1);
        {fifo_write_strobe, fifo_read_strobe} <= 2'b00;
        fo = fm[0];
        fm[0] = ~fm[0];
        rdc(`BBL_FIFO_OUT_OFF, 32'(fo));
        // Write then read of one entry on the next clock; the read-ahead must forward it
        e = 16'($urandom);
        shifter_word <= e;
        fifo_write_strobe <= 1'b1;
        tick(1);
        {fifo_write_strobe, fifo_read_strobe} <= 2'b01;
        tick(1);
        fifo_read_strobe <= 1'b0;
        fo = e;
        rdc(`BBL_FIFO_OUT_OFF, 32'(fo));
        // Destination then source fetched on consecutive clocks
        {mem_en, data_latch_strobe, source_enable_select} <= 3'b110;
        mem_addr <= 4'h3;
        tick(1);
        mem_addr <= 4'h5;
        source_enable_select <= 1'b1;
        tick(1);
        {mem_en, data_latch_strobe} <= 2'b00;
        dst = memv[3];
        tick(1);
        chk(32'(source_latch_word), 32'(memv[5]));
        // Every logic function under the programmed masks
        for (i = 0; i < 16; i++) begin
            fs = 4'(i);
            wr(`BBL_CTRL_OFF, 32'(i), `BBL_RESP_OKAY);
            tick(2);
            e = lu(1'b0, 4'h0);
            chk(32'(result_word), 32'(e));
            rdc(`BBL_RESULT_OFF, 32'(e));
            chk(32'(pixel_data_oe), 32'h0);
        end
        // Logic output stored through the write port
        {source_enable_select, fifo_write_strobe} <= 2'b01;
        tick(1);
        fifo_write_strobe <= 1'b0;
        tick(2);
        fifo_read_strobe <= 1'b1;
        tick(1);
        fifo_read_strobe <= 1'b0;
        fo = e;
        wp = 3;
        rp = 3;
        rdc(`BBL_FIFO_OUT_OFF, 32'(fo));
        // Line drawing: one pixel per address, FIFO strobes and shifter must not matter
        fs = 4'h6;
        wr(`BBL_CTRL_OFF, 32'h6, `BBL_RESP_OKAY);
        line_mode_sel <= 1'b1;
        for (i = 0; i < 16; i++) begin
            b = 1'($urandom);
            pixel_address <= 4'(i);
            pixel_data_in <= b;
            shifter_word <= 16'($urandom);
            {pixel_latch_strobe, fifo_write_strobe, fifo_read_strobe} <= 3'b111;
            tick(1);
            {pixel_latch_strobe, fifo_write_strobe, fifo_read_strobe} <= 3'b000;
            pixel_input_latch = b;
            tick(3);
            e = lu(1'b1, 4'(i));
            chk(32'(result_word), 32'(e));
            chk(32'(pixel_data_out), 32'(e[15 - i]));
            chk(32'(pixel_data_oe), 32'h1);
        end
        rdc(`BBL_STATUS_OFF, st(1'b1));
        line_mode_sel <= 1'b0;
        tick(3);
        chk(32'(pixel_data_oe), 32'h0);
        // Seven-clock controller cycle: two sources, FIFO write, swap, destination with FIFO read in one clock, two clocks to result
        e = 16'($urandom);
        {mem_en, data_latch_strobe, source_enable_select} <= 3'b111;
        mem_addr <= 4'h7;
        tick(1);
        mem_addr <= 4'h8;
        tick(1);
        {mem_en, data_latch_strobe, fifo_write_strobe} <= 3'b001;
        shifter_word <= e;
        tick(1);
        {fifo_write_strobe, source_enable_select, mem_en} <= 3'b001;
        mem_addr <= 4'h9;
        tick(1);
        // Read comes two clocks after the write of that entry
        {data_latch_strobe, fifo_read_strobe} <= 2'b11;
        tick(1);
        {mem_en, data_latch_strobe, fifo_read_strobe} <= 3'b000;
        fo = e;
        dst = memv[9];
        tick(2);
        chk(32'(result_word), 32'(lu(1'b0, 4'h0)));
        chk(32'(source_latch_word), 32'(memv[8]));
        // Reset in mid-run: rings back to entry 0, entry contents kept, first read at once
        aresetn <= 1'b0;
        tick(2);
        {aresetn, fifo_read_strobe} <= 2'b11;
        tick(1);
        fifo_read_strobe <= 1'b0;
        fo = fm[0];
        wp = 0;
        rp = 1;
        pixel_input_latch = 1'b0;
        rdc(`BBL_FIFO_OUT_OFF, 32'(fo));
        rdc(`BBL_STATUS_OFF, st(1'b0));
        rdc(`BBL_CTRL_OFF, 32'h0000000C);
        final_report;
    end
endmodule // tb_top
